/* File: common/dcpp_pkg.sv */
// constants of the display controller peripheral pin block
// assumes a 125 MHz system clock and a free-running flash link clock
package dcpp_pkg;
	localparam int          CLK_NS        = 8;
	localparam int          LED_STEP_NS   = 1000;
	localparam int          LED_STEP_CYC  = (LED_STEP_NS + CLK_NS - 1) / CLK_NS;
	localparam int          CHG_UNIT_NS   = 80;
	localparam int          CHG_UNIT_CYC  = (CHG_UNIT_NS + CLK_NS - 1) / CLK_NS;
	localparam int          SETTLE_NS     = 400;
	localparam int          SETTLE_CYC    = (SETTLE_NS + CLK_NS - 1) / CLK_NS;
	localparam int          DISCH_NS      = 2000;
	localparam int          DISCH_CYC     = (DISCH_NS + CLK_NS - 1) / CLK_NS;
	localparam int          SPI_HALF_CYC  = 4;
	localparam logic [7:0]  FLASH_READ_CMD  = 8'h03;
	localparam logic [23:0] FLASH_INIT_ADDR = 24'h000000;
	localparam int          INIT_BYTES    = 2;
	localparam logic [6:0]  I2C_ADDR_DEF  = 7'h1B;
	localparam logic [7:0]  REG_CTRL      = 8'h00;
	localparam logic [7:0]  REG_STAT      = 8'h01;
	localparam logic [7:0]  REG_TEMP      = 8'h02;
	localparam int          CTRL_RUN_BIT  = 0;
	localparam int          CTRL_THERM_BIT = 1;
	localparam logic [7:0]  CTRL_RESET    = 8'h01;
	localparam int          STAT_DONE_BIT = 0;
	localparam int          STAT_BUSY_BIT = 1;
	localparam int          SAR_BITS      = 8;
	localparam int          FIFO_WIDTH    = 8;
	localparam int          FIFO_DEPTH    = 16;
	localparam logic [1:0]  LED_NONE      = 2'h0;
	localparam logic [1:0]  LED_RED       = 2'h1;
	localparam logic [1:0]  LED_GREEN     = 2'h2;
	localparam logic [1:0]  LED_BLUE      = 2'h3;
endpackage

/* File: common/dcpp_stream_if.sv */
// valid/ready byte stream between the block's own modules
// assumes both ends sit on the same clock
`timescale 1ns/1ns
interface dcpp_stream_if #(parameter int W = 8);
	logic         valid;
	logic         ready;
	logic [W-1:0] data;
	modport src (output valid, output data, input ready);
	modport snk (input valid, input data, output ready);
endinterface

/* File: rtl/dcpp_fifo.sv */
// synchronous fifo, flip-flop storage
// assumes depth is a power of two; one clock for both sides
`timescale 1ns/1ns
module dcpp_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 16
) (
	input wire logic clk_i,
	input wire logic nrst_i,
	dcpp_stream_if.snk wr,
	dcpp_stream_if.src rd
);
	localparam int AW = $clog2(DEPTH);
	localparam logic [AW:0] FULL = (AW + 1)'(DEPTH);

	logic [WIDTH-1:0] mem_q [DEPTH];
	logic [AW-1:0]    wp_q;
	logic [AW-1:0]    rp_q;
	logic [AW:0]      cnt_q;
	logic             push;
	logic             pop;

	assign wr.ready = (cnt_q != FULL);
	assign rd.valid = (cnt_q != '0);
	assign rd.data  = mem_q[rp_q];
	assign push     = wr.valid & wr.ready;
	assign pop      = rd.valid & rd.ready;

	always_ff @(posedge clk_i)
	begin
		if (push)
			mem_q[wp_q] <= wr.data;
	end

	always_ff @(posedge clk_i or negedge nrst_i)
	begin
		if (!nrst_i)
		begin
			wp_q  <= '0;
			rp_q  <= '0;
			cnt_q <= '0;
		end
		else
		begin
			if (push)
				wp_q <= wp_q + 1'b1;
			if (pop)
				rp_q <= rp_q + 1'b1;
			if (push && !pop)
				cnt_q <= cnt_q + 1'b1;
			else if (pop && !push)
				cnt_q <= cnt_q - 1'b1;
		end
	end
endmodule

/* File: rtl/dcpp_top.sv */
// peripheral pins of the display controller: led select, host notify,
// control i2c target, flash serial port, thermistor sar measurement
// assumes external pullups on open-drain pins; flash link clock free-running
// Contract
// RQ1: led select follows sequence; 0 none, 1 red, 2 green, 3 blue
// RQ2: led select outputs held low while reset is asserted
// RQ3: led select stays low for the whole auto-initialization
// RQ4: host notify shows init running, then marks its completion
// RQ5: host notify is high impedance while reset is asserted
// RQ6: i2c target on port 0 carries all host configuration accesses
// RQ7: block is serial controller and drives the flash serial clock
// RQ8: flash select low only while the flash is being accessed
// RQ9: second select kept high since the extra peripheral is unused
// RQ10: receive data sampled from flash data-in pin
// RQ11: transmit data shifted out on flash data-out pin
// RQ12: comparator input is the decision bit of the sar conversion
// RQ13: charge output feeds the external rc reference network
// RQ14: step charge, sample comparator each step, resolve msb first
// RQ15: selects high and serial clock idle when no flash transfer
`timescale 1ns/1ns
module dcpp_top
	import dcpp_pkg::*;
#(
	parameter logic [6:0] I2C_ADDR = I2C_ADDR_DEF
) (
	input  wire logic       sys_clk_i,
	input  wire logic       nrst_i,
	input  wire logic       flash_link_clk_i,
	input  wire logic       ctrl_i2c_clock_i,
	output logic            ctrl_i2c_clock_o,
	output logic            ctrl_i2c_clock_oe_n_o,
	input  wire logic       ctrl_i2c_data_i,
	output logic            ctrl_i2c_data_o,
	output logic            ctrl_i2c_data_oe_n_o,
	output logic            flash_serial_clock_o,
	output logic            flash_select_n_o,
	output logic            aux_select_n_o,
	input  wire logic       flash_data_in_i,
	output logic            flash_data_out_o,
	input  wire logic       thermal_comparator_in_i,
	output logic            thermal_charge_out_o,
	output logic [1:0]      led_colour_select_o,
	output logic            host_notify_o,
	output logic            host_notify_oe_n_o
);
	typedef enum logic [1:0] {S_START, S_FETCH, S_RUN} dcpp_init_t;
	typedef enum logic [2:0] {I_IDLE, I_ADDR, I_AACK, I_WR, I_WACK, I_RD, I_RACK} dcpp_i2c_t;
	typedef enum logic [1:0] {T_IDLE, T_CHG, T_SET, T_DIS} dcpp_sar_t;
	typedef enum logic [2:0] {L_IDLE, L_CMD, L_DATA, L_HAND, L_END} dcpp_link_t;

	localparam int CMD_BITS = 32;

	// system domain state
	dcpp_init_t        init_q;
	logic              start_tg_q;
	logic [15:0]       pattern_q;
	logic [1:0]        nbytes_q;
	logic [7:0]        ctrl_q;
	logic [7:0]        temp_q;
	logic              od_low_q;
	logic              led_en;
	dcpp_stream_if #(.W(FIFO_WIDTH)) fin ();
	dcpp_stream_if #(.W(FIFO_WIDTH)) fout ();

	dcpp_fifo #(
		.WIDTH(FIFO_WIDTH),
		.DEPTH(FIFO_DEPTH)
	) u_fifo (
		.clk_i (sys_clk_i),
		.nrst_i(nrst_i),
		.wr    (fin),
		.rd    (fout)
	);

	// auto-initialization: fetch the led sequence from flash
	assign fout.ready = (init_q == S_FETCH);
	always_ff @(posedge sys_clk_i or negedge nrst_i)
	begin
		if (!nrst_i)
		begin
			init_q     <= S_START;
			start_tg_q <= 1'b0;
			nbytes_q   <= '0;
			pattern_q  <= {LED_BLUE, LED_GREEN, LED_RED, LED_NONE,
			               LED_BLUE, LED_GREEN, LED_RED, LED_NONE};
		end
		else
		begin
			case (init_q)
				S_START:
				begin
					start_tg_q <= ~start_tg_q;
					init_q     <= S_FETCH;
				end
				S_FETCH:
				begin
					if (fout.valid)
					begin
						pattern_q <= {fout.data, pattern_q[15:8]};
						nbytes_q  <= nbytes_q + 1'b1;
						if (nbytes_q == 2'(INIT_BYTES - 1))
							init_q <= S_RUN;
					end
				end
				S_RUN: init_q <= S_RUN;
				default: init_q <= S_START;
			endcase
		end
	end

	// host notify: released in reset, high during init, low once done
	always_ff @(posedge sys_clk_i or negedge nrst_i)
	begin
		if (!nrst_i)
		begin
			host_notify_oe_n_o <= 1'b1; // [RQ5]
			host_notify_o      <= 1'b1;
		end
		else
		begin
			host_notify_oe_n_o <= 1'b0;
			host_notify_o      <= (init_q != S_RUN); // [RQ4]
		end
	end

	// led sequencer
	logic [15:0] step_cnt_q;
	logic [2:0]  step_idx_q;
	assign led_en = (init_q == S_RUN) && ctrl_q[CTRL_RUN_BIT];
	always_ff @(posedge sys_clk_i or negedge nrst_i)
	begin
		if (!nrst_i)
		begin
			step_cnt_q          <= '0;
			step_idx_q          <= '0;
			led_colour_select_o <= LED_NONE; // [RQ2]
		end
		else if (!led_en)
		begin
			step_cnt_q          <= '0;
			step_idx_q          <= '0;
			led_colour_select_o <= LED_NONE; // [RQ3]
		end
		else
		begin
			led_colour_select_o <= pattern_q[{step_idx_q, 1'b0} +: 2]; // [RQ1]
			if (step_cnt_q == 16'(LED_STEP_CYC - 1))
			begin
				step_cnt_q <= '0;
				step_idx_q <= step_idx_q + 1'b1;
			end
			else
				step_cnt_q <= step_cnt_q + 1'b1;
		end
	end

	// i2c target: pins pass two flops, third flop gives the edges
	logic [1:0] scl_s_q;
	logic [1:0] sda_s_q;
	logic       scl_d_q;
	logic       sda_d_q;
	always_ff @(posedge sys_clk_i or negedge nrst_i)
	begin
		if (!nrst_i)
		begin
			scl_s_q  <= 2'h3;
			sda_s_q  <= 2'h3;
			scl_d_q  <= 1'b1;
			sda_d_q  <= 1'b1;
			od_low_q <= 1'b0;
			ctrl_i2c_clock_oe_n_o <= 1'b1;
		end
		else
		begin
			scl_s_q  <= {scl_s_q[0], ctrl_i2c_clock_i};
			sda_s_q  <= {sda_s_q[0], ctrl_i2c_data_i};
			scl_d_q  <= scl_s_q[1];
			sda_d_q  <= sda_s_q[1];
			od_low_q <= 1'b0;
			// no clock stretching: scl is never pulled
			ctrl_i2c_clock_oe_n_o <= 1'b1;
		end
	end
	assign ctrl_i2c_clock_o = od_low_q;
	assign ctrl_i2c_data_o  = od_low_q;

	logic scl;
	logic sda;
	logic i2c_start;
	logic i2c_stop;
	logic scl_rise;
	logic scl_fall;
	assign scl       = scl_s_q[1];
	assign sda       = sda_s_q[1];
	assign i2c_start = scl & scl_d_q & sda_d_q & ~sda;
	assign i2c_stop  = scl & scl_d_q & ~sda_d_q & sda;
	assign scl_rise  = scl & ~scl_d_q;
	assign scl_fall  = ~scl & scl_d_q;

	dcpp_i2c_t  i2c_q;
	logic [7:0] sh_q;
	logic [3:0] bit_q;
	logic       rw_q;
	logic       first_q;
	logic [7:0] ptr_q;
	logic       therm_go_q;
	logic       sar_busy;
	logic [7:0] rdata;

	always_comb
	begin
		case (ptr_q)
			REG_CTRL: rdata = ctrl_q;
			REG_STAT: rdata = {6'h00, sar_busy, init_q == S_RUN};
			REG_TEMP: rdata = temp_q;
			default:  rdata = 8'h00;
		endcase
	end

	// first written byte sets the pointer, later bytes write ctrl_q only while the pointer is REG_CTRL
	always_ff @(posedge sys_clk_i or negedge nrst_i)
	begin
		if (!nrst_i)
		begin
			i2c_q      <= I_IDLE;
			sh_q       <= '0;
			bit_q      <= '0;
			rw_q       <= 1'b0;
			first_q    <= 1'b0;
			ptr_q      <= '0;
			ctrl_q     <= CTRL_RESET;
			therm_go_q <= 1'b0;
			ctrl_i2c_data_oe_n_o <= 1'b1;
		end
		else
		begin
			therm_go_q <= 1'b0;
			if (i2c_stop)
			begin
				i2c_q <= I_IDLE;
				ctrl_i2c_data_oe_n_o <= 1'b1;
			end
			else if (i2c_start)
			begin
				i2c_q   <= I_ADDR;
				bit_q   <= '0;
				first_q <= 1'b1;
				ctrl_i2c_data_oe_n_o <= 1'b1;
			end
			else if (scl_rise)
			begin
				if (i2c_q == I_ADDR || i2c_q == I_WR)
				begin
					sh_q  <= {sh_q[6:0], sda};
					bit_q <= bit_q + 1'b1;
				end
				else if (i2c_q == I_RD)
					bit_q <= bit_q + 1'b1;
				else if (i2c_q == I_RACK && sda)
					i2c_q <= I_IDLE;
			end
			else if (scl_fall)
			begin
				case (i2c_q)
					I_ADDR:
					begin
						if (bit_q == 4'h8)
						begin
							if (sh_q[7:1] == I2C_ADDR)
							begin
								i2c_q <= I_AACK; // [RQ6]
								rw_q  <= sh_q[0];
								ctrl_i2c_data_oe_n_o <= 1'b0;
							end
							else
								i2c_q <= I_IDLE;
						end
					end
					I_AACK, I_RACK:
					begin
						bit_q <= '0;
						if (rw_q)
						begin
							i2c_q <= I_RD;
							sh_q  <= rdata;
							ctrl_i2c_data_oe_n_o <= rdata[7];
						end
						else
						begin
							i2c_q <= I_WR;
							ctrl_i2c_data_oe_n_o <= 1'b1;
						end
					end
					I_WR:
					begin
						if (bit_q == 4'h8)
						begin
							i2c_q   <= I_WACK;
							first_q <= 1'b0;
							ctrl_i2c_data_oe_n_o <= 1'b0;
							if (first_q)
								ptr_q <= sh_q;
							else if (ptr_q == REG_CTRL)
							begin
								ctrl_q     <= sh_q & ~(8'h01 << CTRL_THERM_BIT); // [RQ6]
								therm_go_q <= sh_q[CTRL_THERM_BIT];
							end
						end
					end
					I_WACK:
					begin
						i2c_q <= I_WR;
						bit_q <= '0;
						ctrl_i2c_data_oe_n_o <= 1'b1;
					end
					I_RD:
					begin
						if (bit_q == 4'h8)
						begin
							i2c_q <= I_RACK;
							ctrl_i2c_data_oe_n_o <= 1'b1;
						end
						else
						begin
							sh_q <= {sh_q[6:0], 1'b0};
							ctrl_i2c_data_oe_n_o <= sh_q[6];
						end
					end
					default: i2c_q <= I_IDLE;
				endcase
			end
		end
	end

	// thermistor sar: charge time proportional to trial code
	dcpp_sar_t     sar_q;
	logic [1:0]    cmp_s_q;
	logic [15:0]   sar_cnt_q;
	logic [2:0]    sar_bit_q;
	logic [7:0]    sar_res_q;
	logic [7:0]    trial;
	assign sar_busy = (sar_q != T_IDLE);
	assign trial    = sar_res_q | (8'h01 << sar_bit_q);
	always_ff @(posedge sys_clk_i or negedge nrst_i)
	begin
		if (!nrst_i)
		begin
			sar_q     <= T_IDLE;
			cmp_s_q   <= '0;
			sar_cnt_q <= '0;
			sar_bit_q <= '0;
			sar_res_q <= '0;
			temp_q    <= '0;
			thermal_charge_out_o <= 1'b0;
		end
		else
		begin
			cmp_s_q <= {cmp_s_q[0], thermal_comparator_in_i};
			case (sar_q)
				T_IDLE:
				begin
					thermal_charge_out_o <= 1'b0;
					if (therm_go_q)
					begin
						sar_q     <= T_CHG;
						sar_bit_q <= 3'(SAR_BITS - 1); // [RQ14]
						sar_res_q <= '0;
						sar_cnt_q <= '0;
					end
				end
				T_CHG:
				begin
					thermal_charge_out_o <= 1'b1; // [RQ13]
					sar_cnt_q <= sar_cnt_q + 1'b1;
					if (sar_cnt_q == 16'(trial) * 16'(CHG_UNIT_CYC) - 1'b1)
					begin
						sar_q     <= T_SET;
						sar_cnt_q <= '0;
						thermal_charge_out_o <= 1'b0;
					end
				end
				T_SET:
				begin
					sar_cnt_q <= sar_cnt_q + 1'b1;
					if (sar_cnt_q == 16'(SETTLE_CYC - 1))
					begin
						// comparator low: reference still below, keep the bit
						if (!cmp_s_q[1])
							sar_res_q <= trial; // [RQ12]
						sar_q     <= T_DIS;
						sar_cnt_q <= '0;
					end
				end
				T_DIS:
				begin
					sar_cnt_q <= sar_cnt_q + 1'b1;
					if (sar_cnt_q == 16'(DISCH_CYC - 1))
					begin
						sar_cnt_q <= '0;
						if (sar_bit_q == 3'h0)
						begin
							sar_q  <= T_IDLE;
							temp_q <= sar_res_q;
						end
						else
						begin
							sar_bit_q <= sar_bit_q - 1'b1; // [RQ14]
							sar_q     <= T_CHG;
						end
					end
				end
				default: sar_q <= T_IDLE;
			endcase
		end
	end

	// byte handshake from link: toggle request, data held until ack
	logic [7:0] lbyte_q;
	logic       lreq_tg_q;
	logic [1:0] req_s_q;
	logic       req_d_q;
	logic       ack_tg_q;
	logic       pend_q;
	assign fin.valid = pend_q;
	assign fin.data  = lbyte_q;
	always_ff @(posedge sys_clk_i or negedge nrst_i)
	begin
		if (!nrst_i)
		begin
			req_s_q  <= '0;
			req_d_q  <= 1'b0;
			ack_tg_q <= 1'b0;
			pend_q   <= 1'b0;
		end
		else
		begin
			req_s_q <= {req_s_q[0], lreq_tg_q};
			req_d_q <= req_s_q[1];
			if (req_s_q[1] != req_d_q)
				pend_q <= 1'b1;
			else if (pend_q && fin.ready)
			begin
				// ack withheld while the fifo is full: stalls the flash read
				pend_q   <= 1'b0;
				ack_tg_q <= ~ack_tg_q;
			end
		end
	end

	// flash link domain
	logic [1:0]  lrst_q;
	logic [1:0]  st_s_q;
	logic        st_d_q;
	logic [1:0]  ack_s_q;
	logic [1:0]  din_s_q;
	dcpp_link_t  link_q;
	logic [CMD_BITS-1:0] lsh_q;
	logic [5:0]  lbit_q;
	logic [2:0]  ldiv_q;
	logic [1:0]  lcnt_q;
	logic        half_end;
	assign half_end = (ldiv_q == 3'(SPI_HALF_CYC - 1));

	always_ff @(posedge flash_link_clk_i or negedge nrst_i)
	begin
		if (!nrst_i)
			lrst_q <= '0;
		else
			lrst_q <= {lrst_q[0], 1'b1};
	end

	always_ff @(posedge flash_link_clk_i or negedge lrst_q[1])
	begin
		if (!lrst_q[1])
		begin
			st_s_q  <= '0;
			st_d_q  <= 1'b0;
			ack_s_q <= '0;
			din_s_q <= '0;
			link_q  <= L_IDLE;
			lsh_q   <= '0;
			lbit_q  <= '0;
			ldiv_q  <= '0;
			lcnt_q  <= '0;
			lbyte_q <= '0;
			lreq_tg_q <= 1'b0;
			flash_serial_clock_o <= 1'b0; // [RQ15]
			flash_select_n_o     <= 1'b1;
			aux_select_n_o       <= 1'b1;
			flash_data_out_o     <= 1'b0;
		end
		else
		begin
			st_s_q  <= {st_s_q[0], start_tg_q};
			st_d_q  <= st_s_q[1];
			ack_s_q <= {ack_s_q[0], ack_tg_q};
			din_s_q <= {din_s_q[0], flash_data_in_i};
			aux_select_n_o <= 1'b1; // [RQ9]
			ldiv_q <= half_end ? '0 : ldiv_q + 1'b1;
			case (link_q)
				L_IDLE:
				begin
					flash_select_n_o     <= 1'b1; // [RQ15]
					flash_serial_clock_o <= 1'b0;
					if (st_s_q[1] != st_d_q)
					begin
						link_q <= L_CMD;
						lsh_q  <= {FLASH_READ_CMD, FLASH_INIT_ADDR};
						lbit_q <= '0;
						lcnt_q <= '0;
						ldiv_q <= '0;
						flash_select_n_o <= 1'b0; // [RQ8]
						flash_data_out_o <= FLASH_READ_CMD[7];
					end
				end
				L_CMD, L_DATA:
				begin
					if (half_end)
					begin
						flash_serial_clock_o <= ~flash_serial_clock_o; // [RQ7]
						if (flash_serial_clock_o)
						begin
							// falling edge: shift, sample synced data-in
							lsh_q  <= {lsh_q[CMD_BITS-2:0], din_s_q[1]}; // [RQ10]
							flash_data_out_o <= lsh_q[CMD_BITS-2]; // [RQ11]
							lbit_q <= lbit_q + 1'b1;
							if (link_q == L_CMD && lbit_q == 6'(CMD_BITS - 1))
							begin
								link_q <= L_DATA;
								lbit_q <= '0;
							end
							else if (link_q == L_DATA && lbit_q == 6'h07)
							begin
								link_q    <= L_HAND;
								lbyte_q   <= {lsh_q[6:0], din_s_q[1]};
								lreq_tg_q <= ~lreq_tg_q;
							end
						end
					end
				end
				L_HAND:
				begin
					// serial clock parked low while the byte crosses
					if (ack_s_q[1] == lreq_tg_q)
					begin
						lbit_q <= '0;
						ldiv_q <= '0;
						lcnt_q <= lcnt_q + 1'b1;
						link_q <= (lcnt_q == 2'(INIT_BYTES - 1)) ? L_END : L_DATA;
					end
				end
				L_END:
				begin
					flash_select_n_o <= 1'b1; // [RQ8]
					link_q <= L_END;
				end
				default: link_q <= L_IDLE;
			endcase
		end
	end
endmodule

/* File: tb/dcpp_sva.sv */
// assertions on the pins of the peripheral pin block
// assumes it is bound to dcpp_top and sees only its ports
`timescale 1ns/1ns
module dcpp_sva (
	input wire logic       sys_clk_i,
	input wire logic       nrst_i,
	input wire logic       flash_link_clk_i,
	input wire logic       flash_serial_clock_o,
	input wire logic       flash_select_n_o,
	input wire logic       aux_select_n_o,
	input wire logic       flash_data_out_o,
	input wire logic [1:0] led_colour_select_o,
	input wire logic       host_notify_o,
	input wire logic       host_notify_oe_n_o
);
	sequence sel_fall;
		$fell(flash_select_n_o);
	endsequence
	sequence first_pulse;
		!flash_serial_clock_o [*4] ##1 flash_serial_clock_o;
	endsequence
	// reset-state checks have no disable: the reset state is what they guard
	a_led_reset_low:
	assert property (@(negedge sys_clk_i) !nrst_i |-> led_colour_select_o == 2'h0)
		else $error("led select driven during reset");
	a_notify_reset_rel:
	assert property (@(negedge sys_clk_i) !nrst_i |-> host_notify_oe_n_o)
		else $error("host notify driven during reset");
	a_notify_driven_init:
	assert property (@(posedge sys_clk_i) disable iff (!nrst_i)
		$rose(nrst_i) |=> !host_notify_oe_n_o && host_notify_o)
		else $error("host notify not showing init after reset");
	a_led_off_init:
	assert property (@(posedge sys_clk_i) disable iff (!nrst_i)
		host_notify_o && !host_notify_oe_n_o |-> led_colour_select_o == 2'h0)
		else $error("led enabled during init");
	a_done_stays_low:
	assert property (@(posedge sys_clk_i) disable iff (!nrst_i)
		!host_notify_o && !host_notify_oe_n_o |=> !host_notify_o && !host_notify_oe_n_o)
		else $error("init completion not held");
	a_sck_after_sel:
	assert property (@(posedge flash_link_clk_i) disable iff (!nrst_i)
		sel_fall |-> first_pulse)
		else $error("first serial clock pulse misplaced");
	a_sck_high_four:
	assert property (@(posedge flash_link_clk_i) disable iff (!nrst_i)
		$rose(flash_serial_clock_o) |-> flash_serial_clock_o [*4] ##1 !flash_serial_clock_o)
		else $error("serial clock high phase wrong");
	a_sck_idle_desel:
	assert property (@(posedge flash_link_clk_i) disable iff (!nrst_i)
		flash_select_n_o |-> !flash_serial_clock_o)
		else $error("serial clock runs while deselected");
	a_mosi_stable_high:
	assert property (@(posedge flash_link_clk_i) disable iff (!nrst_i)
		flash_serial_clock_o |-> $stable(flash_data_out_o))
		else $error("data out changed while clock high");
	a_aux_sel_high:
	assert property (@(posedge flash_link_clk_i) disable iff (!nrst_i) aux_select_n_o)
		else $error("second select asserted");
endmodule
bind dcpp_top dcpp_sva dcpp_sva_i (
	.sys_clk_i(sys_clk_i),
	.nrst_i(nrst_i),
	.flash_link_clk_i(flash_link_clk_i),
	.flash_serial_clock_o(flash_serial_clock_o),
	.flash_select_n_o(flash_select_n_o),
	.aux_select_n_o(aux_select_n_o),
	.flash_data_out_o(flash_data_out_o),
	.led_colour_select_o(led_colour_select_o),
	.host_notify_o(host_notify_o),
	.host_notify_oe_n_o(host_notify_oe_n_o)
);

/* File: tb/dcpp_flash_model.sv */
// behavioural serial flash answering one read with two data bytes
// assumes mode 0: data in taken on clock rise, data out changed on fall
`timescale 1ns/1ns
module dcpp_flash_model #(
	parameter logic [15:0] DATA = 16'h0000
) (
	input  wire logic   sck_i,
	input  wire logic   sel_n_i,
	input  wire logic   mosi_i,
	output logic        miso_o,
	output logic [31:0] hdr_o
);
	int n;
	initial
	begin
		n = 0;
		miso_o = 1'b0;
		hdr_o = 32'h0;
	end
	// select fall finds the clock idle low, so it restarts the frame
	always @(posedge sck_i or negedge sel_n_i)
		if (!sck_i)
		begin
			n <= 0;
			hdr_o <= 32'h0;
		end
		else if (!sel_n_i)
		begin
			if (n < 32)
				hdr_o <= {hdr_o[30:0], mosi_i};
			n <= n + 1;
		end
	// released line shows the inverse of its last bit, never a held value
	always @(negedge sck_i or posedge sel_n_i)
		if (sel_n_i)
			miso_o <= ~miso_o;
		else if (n >= 32 && n < 48)
			miso_o <= DATA[47 - n];
endmodule

/* File: tb/dcpp_top_tb.sv */
// self-checking bench of the peripheral pin block with a flash model
// assumes package, checker and flash model are compiled before it
`timescale 1ns/1ns
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin bad_count++; \
	$display("ERROR t=%0t got=%h exp=%h", $time, (g), (e)); end end
module dcpp_top_tb
	import dcpp_pkg::*;
;
	localparam logic [15:0] FDATA = 16'hE41B;
	localparam logic [7:0]  TEMP  = 8'hA5;
	logic        sys_clk_i, nrst_i, link_clk, scl_m, sda_m, cmp, chg_l;
	logic        sck, sel_n, aux_n, mosi, miso, chg, notify, notify_oe_n;
	logic        scl_o, scl_oe_n, sda_o, sda_oe_n;
	logic [1:0]  led;
	logic [31:0] hdr;
	int          bad_count, compares, cyc, plen;
	wire         scl = scl_m & (scl_oe_n | scl_o);
	wire         sda = sda_m & (sda_oe_n | sda_o);
	dcpp_top dcpp_top_i (.sys_clk_i(sys_clk_i), .nrst_i(nrst_i), .flash_link_clk_i(link_clk),
		.ctrl_i2c_clock_i(scl), .ctrl_i2c_clock_o(scl_o), .ctrl_i2c_clock_oe_n_o(scl_oe_n),
		.ctrl_i2c_data_i(sda), .ctrl_i2c_data_o(sda_o), .ctrl_i2c_data_oe_n_o(sda_oe_n),
		.flash_serial_clock_o(sck), .flash_select_n_o(sel_n), .aux_select_n_o(aux_n),
		.flash_data_in_i(miso), .flash_data_out_o(mosi), .thermal_comparator_in_i(cmp),
		.thermal_charge_out_o(chg), .led_colour_select_o(led), .host_notify_o(notify),
		.host_notify_oe_n_o(notify_oe_n));
	dcpp_flash_model #(.DATA(FDATA)) dcpp_flash_model_i (.sck_i(sck), .sel_n_i(sel_n),
		.mosi_i(mosi), .miso_o(miso), .hdr_o(hdr));
	initial
	begin
		sys_clk_i = 0;
		forever #4 sys_clk_i = ~sys_clk_i;
	end
	initial
	begin
		link_clk = 0;
		#7;
		forever #15 link_clk = ~link_clk;
	end
	// rc network stand-in: a longer charge pulse means a higher reference
	always @(negedge sys_clk_i)
	begin
		plen <= chg ? (chg_l ? plen + 1 : 1) : plen;
		chg_l <= chg;
		cmp <= plen > TEMP * CHG_UNIT_CYC + 5;
	end
	always @(posedge sys_clk_i)
	begin
		cyc++;
		if (cyc == 90000)
		begin
			bad_count++;
			report_and_stop();
		end
	end
	task automatic report_and_stop;
		if (bad_count == 0 && compares > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	task automatic wt(input int n);
		repeat (n) @(negedge sys_clk_i);
	endtask
	task automatic xbit(input logic b, output logic r);
		sda_m = b;
		wt(20);
		scl_m = 1;
		wt(20);
		r = sda;
		scl_m = 0;
		wt(20);
	endtask
	task automatic start;
		sda_m = 1;
		scl_m = 1;
		wt(20);
		sda_m = 0;
		wt(20);
		scl_m = 0;
		wt(20);
	endtask
	task automatic stop;
		sda_m = 0;
		wt(20);
		scl_m = 1;
		wt(20);
		sda_m = 1;
		wt(20);
	endtask
	task automatic xbyte(input logic [7:0] b, output logic [7:0] r, output logic ak);
		logic a;
		for (int i = 7; i >= 0; i--)
			xbit(b[i], r[i]);
		xbit(1'b1, a);
		ak = !a;
	endtask
	task automatic wr(input logic [7:0] p, input logic [7:0] v);
		logic [7:0] r;
		logic [2:0] a;
		start();
		xbyte({I2C_ADDR_DEF, 1'b0}, r, a[2]);
		xbyte(p, r, a[1]);
		xbyte(v, r, a[0]);
		stop();
		`CHK(a, 3'h7)
	endtask
	task automatic rd(input logic [7:0] p, output logic [7:0] v);
		logic [3:0] a;
		start();
		xbyte({I2C_ADDR_DEF, 1'b0}, v, a[3]);
		xbyte(p, v, a[2]);
		start();
		xbyte({I2C_ADDR_DEF, 1'b1}, v, a[1]);
		// last bit is the master's nack: the target must have let go of sda
		xbyte(8'hFF, v, a[0]);
		stop();
		`CHK(a, 4'hE)
	endtask
	task automatic t_reset;
		@(negedge sys_clk_i);
		nrst_i = 0;
		wt(16);
		`CHK({led, notify_oe_n, sel_n, aux_n, sck}, 6'h0E)
		nrst_i = 1;
		wt(2);
		`CHK({notify_oe_n, notify}, 2'h1)
	endtask
	task automatic t_init;
		int         k;
		int         s;
		logic [1:0] e;
		for (k = 0; notify !== 1'b0 && k < 20000; k++)
			wt(1);
		`CHK(notify, 1'b0)
		`CHK(hdr, {FLASH_READ_CMD, FLASH_INIT_ADDR})
		// select rises only once the last byte ack has crossed to the link
		wt(20);
		`CHK(sel_n, 1'b1)
		for (k = 0; led !== LED_RED && k < 3000; k++)
			wt(1);
		wt(LED_STEP_CYC / 2);
		for (s = 1; s <= 8; s++)
		begin
			e = FDATA[(s[2] ? 0 : 8) + 2 * s[1:0] +: 2];
			`CHK(led, e)
			wt(LED_STEP_CYC);
		end
	endtask
	task automatic t_regs;
		logic [7:0] v;
		logic       a;
		rd(REG_STAT, v);
		`CHK(v, 8'h01 << STAT_DONE_BIT)
		rd(REG_CTRL, v);
		`CHK(v, CTRL_RESET)
		rd(8'h07, v);
		`CHK(v, 8'h00)
		start();
		xbyte({I2C_ADDR_DEF ^ 7'h01, 1'b0}, v, a);
		stop();
		`CHK(a, 1'b0)
		wr(REG_CTRL, 8'h00);
		wt(LED_STEP_CYC * 2);
		`CHK(led, LED_NONE)
		rd(REG_CTRL, v);
		`CHK(v, 8'h00)
	endtask
	task automatic t_therm;
		logic [7:0] v;
		wr(REG_CTRL, 8'h01 << CTRL_THERM_BIT);
		rd(REG_STAT, v);
		`CHK(v[STAT_BUSY_BIT], 1'b1)
		wt(SAR_BITS * (255 * CHG_UNIT_CYC + SETTLE_CYC + DISCH_CYC));
		rd(REG_STAT, v);
		`CHK(v[STAT_BUSY_BIT], 1'b0)
		rd(REG_TEMP, v);
		`CHK(v, TEMP)
		rd(REG_CTRL, v);
		`CHK(v[CTRL_THERM_BIT], 1'b0)
	endtask
	initial
	begin
		nrst_i = 0;
		scl_m = 1;
		sda_m = 1;
		cmp = 0;
		chg_l = 0;
		plen = 0;
		bad_count = 0;
		compares = 0;
		cyc = 0;
		t_reset();
		t_init();
		t_regs();
		t_therm();
		t_reset();
		t_init();
		report_and_stop();
	end
endmodule
